// ### src/gdms_pkg.sv
/*
 Shared constants for the gate discharge mode selector: register map,
 field layout, reset values and watchdog timing.
 Assumes a 10 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none
package gdms_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned WD_SHORT_MS = 50;
  localparam int unsigned WD_LONG_MS = 200;
  localparam int unsigned WD_SHORT_CYC = CLK_HZ / 1000 * WD_SHORT_MS;
  localparam int unsigned WD_LONG_CYC = CLK_HZ / 1000 * WD_LONG_MS;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MODE_OFS = 8'h04;
  localparam logic [7:0] WDOG_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] GATE_OFS = 8'h10;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_PASS_BIT = 0;
  localparam int unsigned CTRL_ACTIVE_BIT = 1;
  localparam int unsigned CTRL_SLEEP_BIT = 2;
  localparam int unsigned CTRL_WDEN_BIT = 3;
  localparam int unsigned CTRL_WDLONG_BIT = 4;
  localparam int unsigned CTRL_FSCLR_BIT = 5;
  localparam logic [5:0] CTRL_RST = 6'h00;

  // ----------------------------------------------------------------
  // watchdog register: writing the service key restarts the timer
  // ----------------------------------------------------------------
  localparam logic [31:0] WD_KEY = 32'h0000_A5A5;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_FS_BIT = 0;
  localparam int unsigned STAT_WDF_BIT = 1;
  localparam int unsigned STAT_FORCE_BIT = 2;
  localparam int unsigned STAT_PASSIVE_BIT = 3;

  // ----------------------------------------------------------------
  // half-bridge mode codes
  // ----------------------------------------------------------------
  localparam logic [1:0] HB_OFF_LO = 2'h0;
  localparam logic [1:0] HB_OFF_HI = 2'h3;

endpackage : gdms_pkg
`default_nettype wire

// ### src/gdms_wdog.sv
/*
 Watchdog timer for the gate discharge mode selector.
 Assumes service and enable come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module gdms_wdog #(
  parameter int unsigned SHORT_CYC = gdms_pkg::WD_SHORT_CYC,
  parameter int unsigned LONG_CYC = gdms_pkg::WD_LONG_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic enable_i,
  input wire logic long_i,
  input wire logic service_i,
  // result
  output logic expire_o
);

  logic [27:0] count;
  logic [27:0] limit;

  assign limit = long_i ? 28'(LONG_CYC - 1) : 28'(SHORT_CYC - 1);

  // RULE_07: timeout without service
  always_ff @(posedge clk_i) begin
    if (rst_i || !enable_i || service_i) begin
      count <= 28'h0000000;
      expire_o <= 1'b0;
    end else if (count >= limit) begin
      count <= 28'h0000000;
      expire_o <= 1'b1;
    end else begin
      count <= count + 28'h0000001;
      expire_o <= 1'b0;
    end
  end

endmodule : gdms_wdog

`default_nettype wire

// ### src/gdms_top.sv
/*
 Gate discharge mode selector: chooses active current-sink discharge or
 passive pull-down discharge of every external half-bridge gate, and
 runs the watchdog that drives fail safe mode.
 Assumes fault flags arrive as asynchronous levels from the analog
 stage and that software reaches the registers over AHB-Lite.
*/
// Notes on behaviour
// RULE_01: active mode, all bridges off: current sinks discharge every gate.
// RULE_02: passive bit set, all bridges off: pull-down resistors instead.
// RULE_03: sleep mode always uses passive discharge on all gates.
// RULE_04: active mode with no MOSFET on may use passive discharge.
// RULE_05: faults, charge pump off or fail safe force passive discharge.
// RULE_06: pull-up diagnostic current on each high source in active mode.
// RULE_07: watchdog timeout sets failure flag, fail safe, all MOSFETs off.
// RULE_08: selection recomputed every cycle; faults act on next cycle (here on the third edge, via the two-flop synchroniser).
`timescale 1ns/1ps
`default_nettype none

module gdms_top #(
  parameter int unsigned NUM_HB = 8,
  parameter int unsigned WD_SHORT = gdms_pkg::WD_SHORT_CYC,
  parameter int unsigned WD_LONG = gdms_pkg::WD_LONG_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // fault levels from the analog stage
  input wire logic overtemp_i,
  input wire logic supply_uv_i,
  input wire logic supply_ov_i,
  input wire logic cp_uv_i,
  input wire logic cp_off_i,
  // gate drive controls, one bit per half-bridge
  output logic [NUM_HB-1:0] high_sink_en_o,
  output logic [NUM_HB-1:0] low_sink_en_o,
  output logic [NUM_HB-1:0] high_pulldown_en_o,
  output logic [NUM_HB-1:0] low_pulldown_en_o,
  output logic [NUM_HB-1:0] high_source_pullup_en_o,
  output logic [NUM_HB-1:0] high_on_o,
  output logic [NUM_HB-1:0] low_on_o,
  // state
  output logic fail_safe_o
);

  // ----------------------------------------------------------------
  // fault input synchronisers
  // ----------------------------------------------------------------
  // levels only: a glitch shorter than one clock may be missed
  logic [4:0] flt_meta;
  logic [4:0] flt_sync;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flt_meta <= 5'h00;
      flt_sync <= 5'h00;
    end else begin
      flt_meta <= {overtemp_i, supply_uv_i, supply_ov_i, cp_uv_i, cp_off_i};
      flt_sync <= flt_meta;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [5:0] ctrl;
  logic [2*NUM_HB-1:0] halfbridge_mode_field;
  logic fail_safe;
  logic wd_fail;

  wire logic bridge_passive_bit = ctrl[gdms_pkg::CTRL_PASS_BIT];
  wire logic active_mode = ctrl[gdms_pkg::CTRL_ACTIVE_BIT];
  wire logic sleep_mode = ctrl[gdms_pkg::CTRL_SLEEP_BIT];
  wire logic wd_enable = ctrl[gdms_pkg::CTRL_WDEN_BIT];
  wire logic wd_long = ctrl[gdms_pkg::CTRL_WDLONG_BIT];

  // ----------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------
  logic dp_write;
  logic dp_read;
  logic [7:0] dp_addr;

  wire logic ap_valid = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dp_write <= 1'b0;
      dp_read <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_write <= ap_valid && hwrite_i;
      dp_read <= ap_valid && !hwrite_i;
      dp_addr <= ap_valid ? haddr_i[7:0] : dp_addr;
    end
  end

  // whole aligned words only: a byte address must match exactly
  function automatic logic addr_hit(input logic [7:0] a,
    input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction : addr_hit

  wire logic wr_ctrl = dp_write && addr_hit(dp_addr, gdms_pkg::CTRL_OFS);
  wire logic wr_mode = dp_write && addr_hit(dp_addr, gdms_pkg::MODE_OFS);
  wire logic wr_wdog = dp_write && addr_hit(dp_addr, gdms_pkg::WDOG_OFS);
  wire logic wd_service = wr_wdog && hwdata_i == gdms_pkg::WD_KEY;
  wire logic fs_clear = wr_ctrl && hwdata_i[gdms_pkg::CTRL_FSCLR_BIT];

  // ----------------------------------------------------------------
  // watchdog and fail safe
  // ----------------------------------------------------------------
  logic wd_expire;

  gdms_wdog #(
    .SHORT_CYC(WD_SHORT),
    .LONG_CYC(WD_LONG)
  ) u_wdog (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(wd_enable && !fail_safe),
    .long_i(wd_long),
    .service_i(wd_service),
    .expire_o(wd_expire)
  );

  // expiry beats a clear in the same cycle, so a late clear cannot
  // hide a timeout that software never saw
  // RULE_07: enter fail safe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_safe <= 1'b0;
    end else begin
      fail_safe <= wd_expire || (fail_safe && !fs_clear);
    end
  end

  // RULE_07: failure flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wd_fail <= 1'b0;
    end else begin
      wd_fail <= wd_expire || (wd_fail && !fs_clear);
    end
  end

  // ----------------------------------------------------------------
  // control and mode registers
  // ----------------------------------------------------------------
  // clear bit is a strobe: never stored, always reads 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= gdms_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= {1'b0, hwdata_i[4:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      halfbridge_mode_field <= '0;
    end else if (wr_mode) begin
      halfbridge_mode_field <= hwdata_i[2*NUM_HB-1:0];
    end
  end

  // ----------------------------------------------------------------
  // discharge selection
  // ----------------------------------------------------------------
  function automatic logic hb_off(input logic [1:0] m);
    hb_off = (m == gdms_pkg::HB_OFF_LO) || (m == gdms_pkg::HB_OFF_HI);
  endfunction : hb_off

  logic [NUM_HB-1:0] hb_idle;
  logic [NUM_HB-1:0] hb_high;
  logic [NUM_HB-1:0] hb_low;

  // 01 low on, 10 high on; both other codes leave the bridge off
  for (genvar i = 0; i < NUM_HB; i++) begin : g_hb
    assign hb_idle[i] = hb_off(halfbridge_mode_field[2*i +: 2]);
    assign hb_high[i] = halfbridge_mode_field[2*i +: 2] == 2'h2;
    assign hb_low[i] = halfbridge_mode_field[2*i +: 2] == 2'h1;
  end

  wire logic all_idle = &hb_idle;

  // RULE_05: active sinks need the charge pump
  wire logic force_passive = (|flt_sync) || fail_safe;

  // RULE_02: bridge_passive_select when idle
  // RULE_04: idle active mode may save current
  wire logic bridge_passive_select = bridge_passive_bit && all_idle;

  // RULE_03: sleep always passive
  wire logic passive = sleep_mode || !active_mode || force_passive
    || bridge_passive_select;

  // driving is refused while passive is forced or in sleep
  wire logic drive_ok = active_mode && !sleep_mode && !force_passive;

  wire logic [NUM_HB-1:0] next_high_on = drive_ok ? hb_high : '0;
  wire logic [NUM_HB-1:0] next_low_on = drive_ok ? hb_low : '0;

  // RULE_01: sinks on idle or non-driven gates
  wire logic [NUM_HB-1:0] next_high_sink = passive ? '0 : ~next_high_on;
  wire logic [NUM_HB-1:0] next_low_sink = passive ? '0 : ~next_low_on;
  wire logic [NUM_HB-1:0] next_high_pd = passive ? ~next_high_on : '0;
  wire logic [NUM_HB-1:0] next_low_pd = passive ? ~next_low_on : '0;

  // RULE_06: source pull-up in active mode
  wire logic [NUM_HB-1:0] next_pullup =
    (active_mode && !sleep_mode) ? '1 : '0;

  // RULE_08: outputs refreshed every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_on_o <= '0;
      low_on_o <= '0;
    end else begin
      high_on_o <= next_high_on;
      low_on_o <= next_low_on;
    end
  end

  // RULE_01: sink enables
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_sink_en_o <= '0;
      low_sink_en_o <= '0;
    end else begin
      high_sink_en_o <= next_high_sink;
      low_sink_en_o <= next_low_sink;
    end
  end

  // passive pull-downs hold every gate through reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_pulldown_en_o <= '1;
      low_pulldown_en_o <= '1;
    end else begin
      high_pulldown_en_o <= next_high_pd;
      low_pulldown_en_o <= next_low_pd;
    end
  end

  // fail safe shows one cycle late, in step with the gate outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_source_pullup_en_o <= '0;
      fail_safe_o <= 1'b0;
    end else begin
      high_source_pullup_en_o <= next_pullup;
      fail_safe_o <= fail_safe;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  wire logic [31:0] stat_word = {28'h0000000, passive, force_passive,
    wd_fail, fail_safe};
  wire logic [31:0] gate_word = {16'h0000,
    8'(high_pulldown_en_o), 8'(high_sink_en_o)};

  wire logic ap_read = ap_valid && !hwrite_i;
  wire logic rd_ctrl = addr_hit(haddr_i[7:0], gdms_pkg::CTRL_OFS);
  wire logic rd_mode = addr_hit(haddr_i[7:0], gdms_pkg::MODE_OFS);
  wire logic rd_stat = addr_hit(haddr_i[7:0], gdms_pkg::STAT_OFS);
  wire logic rd_gate = addr_hit(haddr_i[7:0], gdms_pkg::GATE_OFS);

  // taken in the address phase; unmapped reads give zero
  wire logic [31:0] next_rdata =
    !ap_read ? 32'h00000000 :
    rd_ctrl ? {27'h0000000, ctrl[4:0]} :
    rd_mode ? 32'(halfbridge_mode_field) :
    rd_stat ? stat_word :
    rd_gate ? gate_word : 32'h00000000;

  // zero-wait slave, always okay
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      hrdata_o <= next_rdata;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end

endmodule : gdms_top

`default_nettype wire

// ### sim/gdms_gate_model.sv
/* Gate node model of the external half-bridge MOSFETs.
 Assumes enables and on commands from gdms_top on the same clock. */
`timescale 1ns/1ps
`default_nettype none
module gdms_gate_model #(parameter int unsigned N = 8) (
  // clock
  input wire logic clk_i,
  // gate drive controls
  input wire logic [N-1:0] hs_i,
  input wire logic [N-1:0] ls_i,
  input wire logic [N-1:0] hp_i,
  input wire logic [N-1:0] lp_i,
  input wire logic [N-1:0] hon_i,
  input wire logic [N-1:0] lon_i,
  // gate node levels
  output logic [N-1:0] hg_o,
  output logic [N-1:0] lg_o
);
  // an undischarged idle gate floats: it toggles, never holds its level
  always_ff @(posedge clk_i) begin
    hg_o <= hon_i | (~(hs_i | hp_i) & ~hg_o);
    lg_o <= lon_i | (~(ls_i | lp_i) & ~lg_o);
  end
endmodule : gdms_gate_model
`default_nettype wire

// ### sim/gdms_top_sva.sv
/* Port checker for gdms_top.
 Assumes one clock domain; bound to every gdms_top below. */
`timescale 1ns/1ps
`default_nettype none
module gdms_top_sva #(parameter int unsigned NUM_HB = 8) (
  // clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // faults
  input wire logic overtemp_i,
  input wire logic supply_uv_i,
  input wire logic supply_ov_i,
  input wire logic cp_uv_i,
  input wire logic cp_off_i,
  // gate controls
  input wire logic [NUM_HB-1:0] high_sink_en_o,
  input wire logic [NUM_HB-1:0] low_sink_en_o,
  input wire logic [NUM_HB-1:0] high_pulldown_en_o,
  input wire logic [NUM_HB-1:0] low_pulldown_en_o,
  input wire logic [NUM_HB-1:0] high_source_pullup_en_o,
  input wire logic [NUM_HB-1:0] high_on_o,
  input wire logic [NUM_HB-1:0] low_on_o,
  input wire logic fail_safe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic flt = overtemp_i | supply_uv_i | supply_ov_i | cp_uv_i | cp_off_i;
  wire logic off = (high_on_o == '0) && (low_on_o == '0);
  wire logic nosink = (high_sink_en_o == '0) && (low_sink_en_o == '0);
  wire logic allpd = (&high_pulldown_en_o) && (&low_pulldown_en_o);
  // pin to output takes three edges; the fourth sample sees the result
  sequence fault_held;
    flt [*4];
  endsequence
  sequence gap_read;
    hsel_i && htrans_i[1] && hready_i && !hwrite_i
      && (haddr_i > 32'h10) && (haddr_i < 32'h100);
  endsequence
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  a_gap_zero: assert property (gap_read |=> hrdata_o == '0)
    else $error("unmapped read not zero");
  a_reset_passive: assert property ($fell(rst_i) |-> allpd && nosink && off)
    else $error("gates not passive after reset");
  a_fault_passive: assert property (
    fault_held |-> off && nosink && allpd)
    else $error("fault did not force passive discharge");
  a_sink_pd_excl: assert property (
    ((high_sink_en_o & high_pulldown_en_o)
      | (low_sink_en_o & low_pulldown_en_o)) == '0)
    else $error("sink and pull-down both on");
  a_off_held: assert property (
    ((~high_on_o & ~(high_sink_en_o | high_pulldown_en_o))
      | (~low_on_o & ~(low_sink_en_o | low_pulldown_en_o))) == '0)
    else $error("idle gate left floating");
  a_idle_uniform: assert property (
    off |-> (high_sink_en_o == '0) || (&high_sink_en_o))
    else $error("idle bridges mix sink and pull-down");
  a_drive_pullup: assert property (
    (high_on_o != '0) |-> &high_source_pullup_en_o)
    else $error("pull-up missing while driving");
  a_fs_all_off: assert property (
    fail_safe_o |-> off && nosink)
    else $error("fail safe with a gate on or sink on");
endmodule : gdms_top_sva
`default_nettype wire
bind gdms_top gdms_top_sva #(.NUM_HB(NUM_HB)) i_gdms_top_sva (.*);

// ### sim/gdms_top_tb.sv
/* Self-checking bench for gdms_top with the gate node model.
 Assumes short watchdog limits are legal parameter values. */
`timescale 1ns/1ps
`default_nettype none
module gdms_top_tb;
  localparam int unsigned N = 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] flt = 5'h00;
  logic [31:0] rd;
  int error_cnt = 0;
  int samples_checked = 0;
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic fs;
  wire logic [N-1:0] hs, ls, hp, lp, pu, hon, lon, hg, lg;
  wire logic [31:0] gw = {lp, hp, ls, hs};
  gdms_top #(.NUM_HB(N), .WD_SHORT(20), .WD_LONG(50)) i_gdms_top (
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(), .overtemp_i(flt[0]),
    .supply_uv_i(flt[1]), .supply_ov_i(flt[2]), .cp_uv_i(flt[3]),
    .cp_off_i(flt[4]), .high_sink_en_o(hs), .low_sink_en_o(ls),
    .high_pulldown_en_o(hp), .low_pulldown_en_o(lp),
    .high_source_pullup_en_o(pu), .high_on_o(hon), .low_on_o(lon),
    .fail_safe_o(fs));
  gdms_gate_model #(.N(N)) i_gdms_gate_model (.clk_i(clk_i), .hs_i(hs),
    .ls_i(ls), .hp_i(hp), .lp_i(lp), .hon_i(hon), .lon_i(lon),
    .hg_o(hg), .lg_o(lg));
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wrap_up;
    if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // active, passive and sleep with every bridge idle
  task automatic t_modes;
    logic [31:0] ctl [3] = '{32'h2, 32'h3, 32'h6};
    logic [31:0] ex [3] = '{32'h0000_FFFF, 32'hFFFF_0000, 32'hFFFF_0000};
    chk("reset gates", gw, 32'hFFFF_0000);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, gdms_pkg::CTRL_OFS, ctl[i]);
      cyc(3);
      chk("gates", gw, ex[i]);
      chk("pullup", {24'h0, pu}, (i == 2) ? 32'h0 : 32'hFF);
      chk("nodes", {16'h0, lg, hg}, 32'h0);
    end
  endtask : t_modes
  // every mode code on bridge 0 with the passive bit set
  task automatic t_drive;
    logic [7:0] h;
    logic [7:0] l;
    xfer(1'b1, gdms_pkg::CTRL_OFS, 32'h3);
    for (int c = 0; c < 4; c++) begin
      h = {7'h0, c == 2};
      l = {7'h0, c == 1};
      xfer(1'b1, gdms_pkg::MODE_OFS, c);
      cyc(3);
      chk("gates", gw, (h | l) != 0 ? {16'h0, ~l, ~h} : 32'hFFFF_0000);
      chk("nodes", {16'h0, lg, hg}, {16'h0, l, h});
    end
  endtask : t_drive
  // each fault while driving, then recovery
  task automatic t_fault;
    xfer(1'b1, gdms_pkg::MODE_OFS, 32'h2);
    xfer(1'b1, gdms_pkg::CTRL_OFS, 32'h2);
    cyc(3);
    chk("drive on", {16'h0, lon, hon}, 32'h1);
    for (int f = 0; f < 5; f++) begin
      @(posedge clk_i);
      flt <= 5'h01 << f;
      cyc(4);
      chk("fault gates", gw, 32'hFFFF_0000);
      chk("fault on", {16'h0, lon, hon}, 32'h0);
      xfer(1'b0, gdms_pkg::STAT_OFS, 32'h0);
      chk("force bit", {31'h0, rd[2]}, 32'h1);
      @(posedge clk_i);
      flt <= 5'h00;
      cyc(5);
      chk("resume on", {16'h0, lon, hon}, 32'h1);
    end
  endtask : t_fault
  // short and long timeouts, wrong key ignored, clear
  task automatic t_wdog;
    xfer(1'b1, gdms_pkg::CTRL_OFS, 32'hA);
    cyc(12);
    xfer(1'b1, gdms_pkg::WDOG_OFS, gdms_pkg::WD_KEY);
    cyc(15);
    chk("served", {31'h0, fs}, 32'h0);
    xfer(1'b1, gdms_pkg::WDOG_OFS, 32'h0000_1234);
    cyc(10);
    chk("expired", {31'h0, fs}, 32'h1);
    chk("fs on", {16'h0, lon, hon}, 32'h0);
    xfer(1'b0, gdms_pkg::STAT_OFS, 32'h0);
    chk("stat", rd & 32'h3, 32'h3);
    // long limit, and the clear strobe lifts fail safe in the same write
    xfer(1'b1, gdms_pkg::CTRL_OFS, 32'h3A);
    cyc(35);
    chk("long alive", {31'h0, fs}, 32'h0);
    cyc(25);
    chk("long expired", {31'h0, fs}, 32'h1);
    xfer(1'b1, gdms_pkg::CTRL_OFS, 32'h22);
    cyc(3);
    chk("cleared", {15'h0, fs, lon, hon}, 32'h1);
    xfer(1'b1, 8'h14, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h14, 32'h0);
    chk("unmapped", rd, 32'h0);
  endtask : t_wdog
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(1);
    t_modes();
    t_drive();
    t_fault();
    t_wdog();
    wrap_up();
  end
  initial begin
    #500_000;
    error_cnt++;
    wrap_up();
  end
endmodule : gdms_top_tb
`default_nettype wire
